// ===== design/dsbsp_port.sv
// Operation
// - Accesses start only at positive input rise
// - Read: select high, enable low, two words
// - First word at t+1.5, second at t+2
// - New read accepted every positive rise
// - Idle: finish reads, then release outputs
// - Write: select low, enable low, store address
// - Two write words, committed as one burst
// - New write accepted every positive rise
// - Idle: finish writes, ignore other inputs
// - Lane masks sampled per word, low writes
// - Output clocks high at power-on: single clock
// - Write after read is posted, committed later
// - Impedance re-tuned every 1024 cycles
// - Two free-running echo clocks driven
// - Loop locks 1024 cycles after stable clock
// - Clocks stopped 30 ns reset the loop
// - Loop disabled: one cycle read latency
// - Power-up deselected, read outputs released
// - Mask zero bits 8:0, one bits 17:9
`timescale 1ns/1ps
module dsbsp_port
  import dsbsp_pkg::*;
#(
  parameter int WORDS = 64
) (
  input  wire logic                          mclk_in,
  input  wire logic                          reset_in,
  input  wire logic                          ce_in,
  input  wire logic                          kclk_in,
  input  wire logic                          kclk_n_in,
  input  wire logic                          cclk_in,
  input  wire logic                          cclk_n_in,
  input  wire logic                          loop_disable_n_in,
  input  wire logic                          impedance_sense_in,
  input  wire dsbsp_pkg::dsbsp_pins_t        pins_in,
  output logic [dsbsp_pkg::WORD_W-1:0]       rdata_out,
  output logic                               rdata_oe_n_out,
  output logic                               echo_timing_out,
  output logic                               echo_timing_n_out,
  output logic                               loop_locked_out,
  output logic                               single_clock_out,
  output logic [3:0]                         impedance_code_out,
  output logic                               impedance_update_out
);
  import dsbsp_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [3:0]  clk_s1;
  logic [3:0]  clk_s2;
  logic [3:0]  clk_d;
  dsbsp_pins_t pins_s1;
  dsbsp_pins_t pins_s2;
  logic        loop_disable_n_s1;
  logic        loop_disable_n_s2;
  logic        zq_s1;
  logic        zq_s2;

  always_ff @(posedge mclk_in) begin
    if (ce_in) begin
      clk_s1  <= {cclk_n_in, cclk_in, kclk_n_in, kclk_in};
      clk_s2  <= clk_s1;
      clk_d   <= clk_s2;
      pins_s1 <= pins_in;
      pins_s2 <= pins_s1;
      loop_disable_n_s1 <= loop_disable_n_in;
      loop_disable_n_s2 <= loop_disable_n_s1;
      zq_s1   <= impedance_sense_in;
      zq_s2   <= zq_s1;
    end
  end

  wire k_rise  = clk_s2[0] && !clk_d[0];
  wire kn_rise = clk_s2[1] && !clk_d[1];
  wire c_rise_raw  = clk_s2[2] && !clk_d[2];
  wire cn_rise_raw = clk_s2[3] && !clk_d[3];

  // ************************************************************
  // Strap capture after reset release
  // ************************************************************
  logic strap_done;
  logic single_clock;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      strap_done   <= 1'b0;
      single_clock <= 1'b0;
    end else if (ce_in && !strap_done && k_rise) begin
      strap_done   <= 1'b1;
      single_clock <= clk_s2[2] && clk_s2[3];
    end
  end

  wire p_out_rise = single_clock ? k_rise  : c_rise_raw;
  wire n_out_rise = single_clock ? kn_rise : cn_rise_raw;

  // ************************************************************
  // Loop lock and stop detection
  // ************************************************************
  logic [$clog2(LOCK_CYCLES):0] lock_cnt;
  logic [$clog2(STOP_CYCLES):0] idle_cnt;
  wire  loop_on   = loop_disable_n_s2;
  wire  clk_stall = (idle_cnt == ($clog2(STOP_CYCLES)+1)'(STOP_CYCLES));

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      idle_cnt <= '0;
    end else if (ce_in) begin
      if (k_rise || kn_rise) begin
        idle_cnt <= '0;
      end else if (!clk_stall) begin
        idle_cnt <= idle_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in || !loop_on) begin
      lock_cnt <= '0;
    end else if (ce_in) begin
      if (clk_stall) begin
        lock_cnt <= '0;
      end else if (k_rise && lock_cnt != ($clog2(LOCK_CYCLES)+1)'(LOCK_CYCLES)) begin
        lock_cnt <= lock_cnt + 1'b1;
      end
    end
  end
  wire locked = (lock_cnt == ($clog2(LOCK_CYCLES)+1)'(LOCK_CYCLES));

  // ************************************************************
  // Impedance tuning
  // ************************************************************
  logic [$clog2(ZQ_PERIOD)-1:0] zq_cnt;
  logic [3:0]                   zq_code;
  logic                         zq_pulse;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      zq_cnt   <= '0;
      zq_code  <= 4'h8;
      zq_pulse <= 1'b0;
    end else if (ce_in) begin
      zq_pulse <= 1'b0;
      if (k_rise) begin
        zq_cnt <= zq_cnt + 1'b1;
        if (zq_cnt == '1) begin
          zq_pulse <= 1'b1;
          if (zq_s2 && zq_code != 4'hF) begin
            zq_code <= zq_code + 4'h1;
          end else if (!zq_s2 && zq_code != 4'h0) begin
            zq_code <= zq_code - 4'h1;
          end
        end
      end
    end
  end

  // ************************************************************
  // Write path: posted write register and array
  // ************************************************************
  logic [WORD_W-1:0] array_lo [WORDS];
  logic [WORD_W-1:0] array_hi [WORDS];
  dsbsp_wr_t         posted;
  logic              posted_valid;
  logic              wr_addr_valid;
  logic [ADDR_W-1:0] wr_addr;
  logic              wr_phase;

  wire access  = k_rise && !pins_s2.transfer_enable_n;
  wire rd_req  = access && pins_s2.rd_w;
  wire wr_req  = access && !pins_s2.rd_w;
  wire wdata_k = k_rise && wr_addr_valid;

  // commit posted write
  // A finished burst is retired before the next burst's first word can overwrite it
  wire commit = (wr_req || wdata_k) && posted_valid;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_addr_valid <= 1'b0;
      wr_phase      <= 1'b0;
      posted_valid  <= 1'b0;
      wr_addr       <= '0;
      posted        <= '0;
    end else if (ce_in) begin
      if (k_rise) begin
        wr_addr_valid <= wr_req;
        wr_addr       <= pins_s2.addr;
      end
      if (wdata_k) begin
        posted.addr      <= wr_addr;
        posted.lo        <= pins_s2.data;
        posted.mask_lo_n <= pins_s2.byte_lane_mask_n;
        wr_phase         <= 1'b1;
        posted_valid     <= 1'b0;
      end else if (kn_rise && wr_phase) begin
        posted.hi        <= pins_s2.data;
        posted.mask_hi_n <= pins_s2.byte_lane_mask_n;
        wr_phase         <= 1'b0;
        posted_valid     <= 1'b1;
      end else if (commit) begin
        posted_valid <= 1'b0;
      end
    end
  end

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    always_ff @(posedge mclk_in) begin
      if (ce_in && commit) begin
        if (!posted.mask_lo_n[l]) begin
          array_lo[posted.addr][l*LANE_W +: LANE_W] <= posted.lo[l*LANE_W +: LANE_W];
        end
        if (!posted.mask_hi_n[l]) begin
          array_hi[posted.addr][l*LANE_W +: LANE_W] <= posted.hi[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // posted forwarding
  wire  hit = posted_valid && posted.addr == pins_s2.addr;
  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] a,
                                              input logic [WORD_W-1:0] p,
                                              input logic [LANES-1:0] m);
    logic [WORD_W-1:0] r;
    r = a;
    for (int i = 0; i < LANES; i++) begin
      if (!m[i]) begin
        r[i*LANE_W +: LANE_W] = p[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction
  wire [WORD_W-1:0] rd_lo = hit ? merge(array_lo[pins_s2.addr], posted.lo, posted.mask_lo_n)
                                : array_lo[pins_s2.addr];
  wire [WORD_W-1:0] rd_hi = hit ? merge(array_hi[pins_s2.addr], posted.hi, posted.mask_hi_n)
                                : array_hi[pins_s2.addr];

  // Burst words queue up so back to back reads never overrun the output stage
  logic              fifo_ready;
  logic              fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  logic              second_pending;
  logic [WORD_W-1:0] second_word;
  logic              take;
  logic [WORD_W-1:0] second_word_in;
  logic              rd_stage_valid;
  logic [2*WORD_W-1:0] rd_stage_data;

  // loop on: burst waits one K cycle before it may launch
  wire                rd_push      = loop_on ? (k_rise && rd_stage_valid) : rd_req;
  wire [2*WORD_W-1:0] rd_push_data = loop_on ? rd_stage_data : {rd_hi, rd_lo};

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rd_stage_valid <= 1'b0;
      rd_stage_data  <= '0;
    end else if (ce_in && k_rise) begin
      rd_stage_valid <= rd_req;
      rd_stage_data  <= {rd_hi, rd_lo};
    end
  end

  dsbsp_fifo #(
    .WIDTH (2*WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .reset_in      (reset_in),
    .ce_in         (ce_in),
    .in_valid_in   (rd_push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (rd_push_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (take),
    .out_data_out  ({second_word_in, fifo_data})
  );

  wire first_edge  = loop_on ? n_out_rise : p_out_rise;
  wire second_edge = loop_on ? p_out_rise : n_out_rise;
  wire out_edge    = p_out_rise || n_out_rise;
  assign take = first_edge && fifo_valid && !second_pending;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_out      <= '0;
      rdata_oe_n_out <= 1'b1;
      second_pending <= 1'b0;
      second_word    <= '0;
    end else if (ce_in) begin
      if (take) begin
        rdata_out      <= fifo_data;
        rdata_oe_n_out <= 1'b0;
        second_pending <= 1'b1;
        second_word    <= second_word_in;
      end else if (second_edge && second_pending) begin
        rdata_out      <= second_word;
        second_pending <= 1'b0;
      end else if (out_edge && !second_pending) begin
        rdata_oe_n_out <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Echo clocks and status
  // ************************************************************
  // echo clocks follow
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      echo_timing_out   <= 1'b0;
      echo_timing_n_out <= 1'b0;
    end else if (ce_in) begin
      echo_timing_out   <= single_clock ? clk_s2[0] : clk_s2[2];
      echo_timing_n_out <= single_clock ? clk_s2[1] : clk_s2[3];
    end
  end

  assign loop_locked_out      = locked;
  assign single_clock_out     = single_clock;
  assign impedance_code_out   = zq_code;
  assign impedance_update_out = zq_pulse;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  read_fill_a: assert property (rd_push && ce_in |-> fifo_ready)
    else $error("read queue full on accepted read");
  hiz_release_a: assert property (ce_in && out_edge && !second_pending
                                  && !take |=> rdata_oe_n_out)
    else $error("read outputs not released when idle");
  burst_pair_a: assert property (ce_in && take |=> second_pending && !rdata_oe_n_out)
    else $error("first read word without second pending");
  post_set_a: assert property (ce_in && kn_rise && wr_phase |=> posted_valid)
    else $error("second write word not posted");
  commit_clear_a: assert property (ce_in && commit && !kn_rise |=> !posted_valid)
    else $error("posted write not retired");
  zq_pulse_a: assert property (zq_pulse |=> !zq_pulse)
    else $error("impedance update longer than one cycle");
  lock_stall_a: assert property (ce_in && clk_stall |=> !locked)
    else $error("loop stays locked with stopped clocks");
  strap_hold_a: assert property (strap_done |=> $stable(single_clock))
    else $error("single clock strap changed");

  read_c: cover property (rd_req ##[1:20] take);
  write_c: cover property (commit);
  lock_c: cover property ($rose(locked));
endmodule

// ===== design/dsbsp_pkg.sv
package dsbsp_pkg;

  // ************************************************************
  // Widths and timing
  // ************************************************************
  localparam int WORD_W        = 18;
  localparam int LANE_W        = 9;
  localparam int LANES         = 2;
  localparam int ADDR_W        = 6;
  localparam int ZQ_PERIOD     = 1024;
  localparam int LOCK_CYCLES   = 1024;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int STOP_TIME_PS  = 30000;
  localparam int STOP_CYCLES   = (STOP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FIFO_DEPTH    = 4;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic [LANES-1:0]    mask_lo_n;
    logic [LANES-1:0]    mask_hi_n;
    logic [WORD_W-1:0]   lo;
    logic [WORD_W-1:0]   hi;
  } dsbsp_wr_t;

  typedef struct packed {
    logic                rd_w;
    logic                transfer_enable_n;
    logic [ADDR_W-1:0]   addr;
    logic [LANES-1:0]    byte_lane_mask_n;
    logic [WORD_W-1:0]   data;
  } dsbsp_pins_t;

endpackage

// ===== design/dsbsp_fifo.sv
`timescale 1ns/1ps
module dsbsp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  input  wire logic             ce_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce_in) begin
      if (push) begin
        mem[wr_ptr] <= in_data_in;
        wr_ptr      <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== testbench/dsbsp_ctrl_model.sv
`timescale 1ns/1ps
module dsbsp_ctrl_model (
  input  wire logic                          oe_n_in,
  input  wire logic [dsbsp_pkg::WORD_W-1:0]  rdata_in,
  output logic                               kclk_out,
  output logic                               kclk_n_out,
  output logic                               cclk_out,
  output logic                               cclk_n_out,
  output dsbsp_pkg::dsbsp_pins_t             pins_out
);
  import dsbsp_pkg::*;

  int                slot;
  logic [WORD_W-1:0] rd_q[$];
  int                rd_slot_q[$];

  // Clocks rest low/high between frames, so no edge is seen there
  initial begin
    slot = 0;
    kclk_out = 1'b0;
    kclk_n_out = 1'b1;
    cclk_out = 1'b0;
    cclk_n_out = 1'b1;
    pins_out = '0;
    pins_out.transfer_enable_n = 1'b1;
  end

  // ********************
  // Half cycle of the link
  // ********************
  // Word of the edge before last is settled here; the last is not
  // link clock scaled down with the system clock
  task automatic half(input dsbsp_pins_t p, input logic k);
    if (oe_n_in === 1'b0) begin
      rd_q.push_back(rdata_in);
      rd_slot_q.push_back(slot - 2);
    end
    pins_out <= p;
    #8;
    kclk_out <= k;
    kclk_n_out <= !k;
    cclk_out <= k;
    cclk_n_out <= !k;
    slot++;
    #8;
  endtask

  task automatic cycle(input dsbsp_pins_t at_k, input dsbsp_pins_t at_kb);
    half(at_k, 1'b1);
    half(at_kb, 1'b0);
  endtask
endmodule

// ===== testbench/tb_ddr_sio_burst_sram_port.sv
`timescale 1ns/1ps
module tb_ddr_sio_burst_sram_port;
  import dsbsp_pkg::*;

  localparam logic [ADDR_W-1:0] addr_a = 6'h05;
  localparam logic [ADDR_W-1:0] addr_b = 6'h1A;
  localparam logic [ADDR_W-1:0] addr_c = 6'h2C;
  localparam logic [WORD_W-1:0] a_lo   = 18'h12345;
  localparam logic [WORD_W-1:0] a_hi   = 18'h0ABCD;
  localparam logic [WORD_W-1:0] c_lo   = 18'h2F00F;
  localparam logic [WORD_W-1:0] c_hi   = 18'h10C3A;
  logic              mclk;
  logic              reset_in;
  logic              loop_off_n;
  logic              kclk, kclk_n, cclk, cclk_n;
  dsbsp_pins_t       pins;
  logic [WORD_W-1:0] rdata;
  logic              oe_n, echo, echo_n, locked, single, zq_upd, echo_d, echo_n_d;
  logic [3:0]        zq_code;
  int                mismatches, num_checks, echo_rises, echo_n_rises, zq_pulses;

  dsbsp_port #(.WORDS(64)) dut (
    .mclk_in(mclk), .reset_in(reset_in), .ce_in(1'b1),
    .kclk_in(kclk), .kclk_n_in(kclk_n), .cclk_in(cclk), .cclk_n_in(cclk_n),
    .loop_disable_n_in(loop_off_n), .impedance_sense_in(1'b1), .pins_in(pins),
    .rdata_out(rdata), .rdata_oe_n_out(oe_n), .echo_timing_out(echo),
    .echo_timing_n_out(echo_n), .loop_locked_out(locked), .single_clock_out(single),
    .impedance_code_out(zq_code), .impedance_update_out(zq_upd));

  dsbsp_ctrl_model ctrl (
    .oe_n_in(oe_n), .rdata_in(rdata), .kclk_out(kclk), .kclk_n_out(kclk_n),
    .cclk_out(cclk), .cclk_n_out(cclk_n), .pins_out(pins));

  always #2 mclk = ~mclk;

  always @(posedge mclk) begin
    echo_d <= echo;
    echo_n_d <= echo_n;
    if (echo === 1'b1 && echo_d === 1'b0) echo_rises++;
    if (echo_n === 1'b1 && echo_n_d === 1'b0) echo_n_rises++;
    if (zq_upd === 1'b1) zq_pulses++;
  end

  // ********************
  // Shared tasks
  // ********************
  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic dsbsp_pins_t pin(logic rw, logic en_n, logic [ADDR_W-1:0] a,
                                      logic [LANES-1:0] m, logic [WORD_W-1:0] d);
    return '{rd_w: rw, transfer_enable_n: en_n, addr: a, byte_lane_mask_n: m, data: d};
  endfunction

  // Control on the Kbar half is a fake read that must be ignored
  task automatic step(input logic rw, input logic en_n, input logic [ADDR_W-1:0] a,
                      input logic [LANES-1:0] m0, input logic [WORD_W-1:0] d0,
                      input logic [LANES-1:0] m1, input logic [WORD_W-1:0] d1);
    ctrl.cycle(pin(rw, en_n, a, m0, d0), pin(1'b1, 1'b0, ~a, m1, d1));
  endtask

  // Idle carries junk aimed at addr_a with all lanes enabled
  task automatic idle();
    step(1'b0, 1'b1, addr_a, 2'h0, 18'h2AAAA, 2'h0, 18'h15555);
  endtask

  task automatic get_rd(input int s0, input int lat, input logic [WORD_W-1:0] e[$]);
    repeat (4) idle();
    check(WORD_W'(ctrl.rd_q.size()), WORD_W'(e.size()));
    check(WORD_W'(ctrl.rd_slot_q[0] - s0), WORD_W'(lat));
    foreach (e[i]) check(ctrl.rd_q[i], e[i]);
    check(oe_n, 1'b1);
    ctrl.rd_q.delete();
    ctrl.rd_slot_q.delete();
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    check(oe_n, 1'b1);
    repeat (3) idle();
    check(oe_n, 1'b1);
    check(locked, 1'b0);
    check(single, 1'b0);
  endtask

  // Back to back writes, masked rewrite posted, then back to back reads
  task automatic t_wr_rd();
    int s0;
    step(1'b0, 1'b0, addr_a, 2'h3, 18'h0, 2'h3, 18'h0);
    step(1'b0, 1'b0, addr_b, 2'h0, a_lo, 2'h0, a_hi);
    step(1'b0, 1'b0, addr_b, 2'h0, 18'h3FFFF, 2'h0, 18'h00000);
    s0 = ctrl.slot;
    step(1'b1, 1'b0, addr_a, 2'h2, 18'h00000, 2'h1, 18'h15555);
    step(1'b1, 1'b0, addr_b, 2'h0, 18'h3FFFF, 2'h0, 18'h3FFFF);
    get_rd(s0, 3, '{a_lo, a_hi, 18'h3FE00, 18'h15400});
  endtask

  // New write commits the posted one; idle junk left addr_a alone
  task automatic t_post();
    int s0;
    step(1'b0, 1'b0, addr_c, 2'h0, 18'h3FFFF, 2'h0, 18'h3FFFF);
    s0 = ctrl.slot;
    step(1'b1, 1'b0, addr_b, 2'h0, c_lo, 2'h0, c_hi);
    step(1'b1, 1'b0, addr_a, 2'h0, 18'h0, 2'h0, 18'h0);
    step(1'b1, 1'b0, addr_c, 2'h0, 18'h0, 2'h0, 18'h0);
    get_rd(s0, 3, '{18'h3FE00, 18'h15400, a_lo, a_hi, c_lo, c_hi});
  endtask

  task automatic t_dll_off();
    int s0;
    @(posedge mclk);
    loop_off_n <= 1'b0;
    repeat (2) idle();
    s0 = ctrl.slot;
    step(1'b1, 1'b0, addr_a, 2'h0, 18'h0, 2'h0, 18'h0);
    get_rd(s0, 2, '{a_lo, a_hi});
    @(posedge mclk);
    loop_off_n <= 1'b1;
  endtask

  task automatic t_lock();
    int e0;
    int n0;
    int z0;
    e0 = echo_rises;
    n0 = echo_n_rises;
    z0 = zq_pulses;
    repeat (2048) idle();
    check(locked, 1'b1);
    check(WORD_W'(echo_rises - e0), 18'h00800);
    check(WORD_W'(echo_n_rises - n0), 18'h00800);
    check(WORD_W'(zq_pulses - z0), 18'h00002);
    check(WORD_W'(zq_code), 18'h0000A);
  endtask

  // Both input clocks halted well past 30 ns
  task automatic t_stall();
    logic [WORD_W-1:0] q;
    logic              o;
    q = rdata;
    o = oe_n;
    #60;
    check(locked, 1'b0);
    check(rdata, q);
    check(oe_n, o);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Run needs about 70 us; the limit leaves twice that
  initial begin
    #150000;
    mismatches++;
    end_of_test();
  end

  initial begin
    mclk = 1'b0;
    reset_in = 1'b1;
    loop_off_n = 1'b1;
    repeat (5) @(posedge mclk);
    reset_in <= 1'b0;
    @(posedge mclk);
    #2;
    t_reset();
    t_wr_rd();
    t_post();
    t_dll_off();
    t_lock();
    t_stall();
    end_of_test();
  end
endmodule
